// [core/hiccup_timer.sv]
/*
 * Restart interval counter for hiccup recovery.
 * Assumes start is a one-cycle pulse on clk_sys; done pulses once per interval.
 */
`timescale 1ns/1ps
`default_nettype none

module hiccup_timer #(
	parameter int interval = vout_mgr_pkg::hiccup_cycles
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic start,
	input wire logic cancel,
	output logic running,
	output logic done
);

	logic [31:0] count;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			count <= 32'h0;
			running <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (cancel) begin
				running <= 1'b0;
			end else if (start) begin
				running <= 1'b1;
				count <= 32'(interval - 1);
			end else if (running) begin
				if (count == 32'h0) begin
					running <= 1'b0;
					done <= 1'b1;
				end else begin
					count <= count - 32'h1;
				end
			end
		end
	end

endmodule // hiccup_timer

`default_nettype wire

// [core/strap_lookup.sv]
/*
 * Maps a strap resistor code to its output voltage in millivolts.
 * Assumes the analog front end delivers a five-bit code: 0 short, 1..20 the
 * listed resistors in ascending order, 31 open. Output is registered.
 */
`timescale 1ns/1ps
`default_nettype none

module strap_lookup (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [4:0] code,
	output logic [15:0] millivolts
);

	logic [15:0] next_millivolts;

	always_comb begin
		case (code)
			5'h00: next_millivolts = 16'd1000;
			5'h01: next_millivolts = 16'd600;
			5'h02: next_millivolts = 16'd650;
			5'h03: next_millivolts = 16'd700;
			5'h04: next_millivolts = 16'd750;
			5'h05: next_millivolts = 16'd800;
			5'h06: next_millivolts = 16'd850;
			5'h07: next_millivolts = 16'd900;
			5'h08: next_millivolts = 16'd950;
			5'h09: next_millivolts = 16'd1000;
			5'h0a: next_millivolts = 16'd1050;
			5'h0b: next_millivolts = 16'd1100;
			5'h0c: next_millivolts = 16'd1150;
			5'h0d: next_millivolts = 16'd1200;
			5'h0e: next_millivolts = 16'd1250;
			5'h0f: next_millivolts = 16'd1300;
			5'h10: next_millivolts = 16'd1400;
			5'h11: next_millivolts = 16'd1500;
			5'h12: next_millivolts = 16'd1600;
			5'h13: next_millivolts = 16'd1700;
			5'h14: next_millivolts = 16'd1800;
			default: next_millivolts = 16'd1200;
		endcase
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			millivolts <= 16'h04b0;
		end else begin
			millivolts <= next_millivolts;
		end
	end

endmodule // strap_lookup

`default_nettype wire

// [core/vout_mgr_pkg.sv]
/*
 * Shared constants and types of the output setpoint and over-voltage manager:
 * APB register offsets, reset values, field layouts and timing counts.
 * Assumes a 25 MHz system clock and voltages coded in millivolts, 16 bits wide.
 */

package vout_mgr_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] offset_operation = 8'h00;
	localparam logic [7:0] offset_vout_command = 8'h04;
	localparam logic [7:0] offset_vout_trim = 8'h08;
	localparam logic [7:0] offset_margin_high = 8'h0c;
	localparam logic [7:0] offset_margin_low = 8'h10;
	localparam logic [7:0] offset_vout_max = 8'h14;
	localparam logic [7:0] offset_ov_limit = 8'h18;
	localparam logic [7:0] offset_ov_response = 8'h1c;
	localparam logic [7:0] offset_over_under_fault_config = 8'h20;
	localparam logic [7:0] offset_loop_gain_residual_config = 8'h24;
	localparam logic [7:0] offset_clear_faults = 8'h28;
	localparam logic [7:0] offset_status = 8'h2c;
	localparam logic [7:0] offset_target = 8'h30;
	localparam logic [7:0] offset_nvm_load = 8'h34;

	// ----------------------------------------------------------------
	// Field positions and codes
	// ----------------------------------------------------------------
	localparam int operation_on_bit = 7;
	localparam int source_select_bit = 0;
	localparam logic [1:0] margin_none = 2'h0;
	localparam logic [1:0] margin_low = 2'h1;
	localparam logic [1:0] margin_high = 2'h2;
	localparam logic response_latch = 1'b0;
	localparam logic response_hiccup = 1'b1;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic response_reset = response_hiccup;
	localparam logic [15:0] loop_gain_reset = 16'h0080;
	localparam logic [15:0] loop_residual_reset = 16'h0050;
	localparam logic [15:0] vout_max_reset = 16'hffff;

	// ----------------------------------------------------------------
	// Percent figures and timing
	// ----------------------------------------------------------------
	localparam int margin_percent = 5;
	localparam int ceiling_percent = 115;
	localparam int ov_percent = 15;
	localparam int sys_clock_hz = 25000000;
	localparam int hiccup_interval_ms = 10;
	localparam int hiccup_cycles = (sys_clock_hz / 1000) * hiccup_interval_ms;
	localparam int pwm_period_ns = 2000;
	localparam int pwm_cycles = (pwm_period_ns * (sys_clock_hz / 1000000)) / 1000;

	// ----------------------------------------------------------------
	// Carried groups
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] command;
		logic [15:0] trim;
		logic [15:0] margin_hi;
		logic [15:0] margin_lo;
		logic [1:0] margin_sel;
	} setpoint_type;

	typedef struct packed {
		logic [15:0] gain;
		logic [15:0] residual;
	} loop_type;

endpackage

// [core/vout_setpoint_and_overvoltage_manager.sv]
/*
 * Output setpoint and output over-voltage fault manager with an APB slave.
 * Assumes strap code, enable pin, over-voltage comparator and sync clock are
 * asynchronous pins; NVM load pulses come from same-clock init logic.
 */
// Behaviour
// - Strap code maps to a fixed voltage table.
// - Strap sampled only during initialization.
// - Enable from pin or operation command.
// - Open enable pin reads as high.
// - Voltage command write replaces strap setpoint.
// - Margin high/low select margin levels, default 5%.
// - Margining works with either enable source.
// - Trim adds to commanded voltage.
// - Ceiling is 115% of strap voltage.
// - Ceiling clamps target, command reads back unchanged.
// - Maximum command write lowers ceiling.
// - Default over-voltage threshold 15% above nominal.
// - Latch-off holds output off until clear/re-enable.
// - Hiccup disables then retries at interval.
// - Response defaults to hiccup after reset.
// - Host reprograms threshold and response mode.
// - Loop gain and residual stored, moderate default.
// - Loop update every switching cycle.
// - NVM values overwrite strap command at init.
`timescale 1ns/1ps
`default_nettype none

module vout_setpoint_and_overvoltage_manager #(
	parameter int hiccup_interval = vout_mgr_pkg::hiccup_cycles
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [4:0] strap_resistor,
	input wire logic init_done,
	input wire logic nvm_load,
	input wire logic [15:0] nvm_vout_command,
	input wire logic enable_pin,
	input wire logic ov_comparator,
	input wire logic sync_clock,
	output logic output_enable,
	output logic [15:0] target_mv,
	output logic [15:0] ov_limit_mv,
	output logic loop_update,
	output logic fault_active
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [4:0] strap_meta;
	logic [4:0] strap_sync;
	logic [2:0] pin_meta;
	logic [2:0] pin_sync;
	logic sync_clock_last;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			strap_meta <= 5'h1f;
			strap_sync <= 5'h1f;
			pin_meta <= 3'h1;
			pin_sync <= 3'h1;
			sync_clock_last <= 1'b0;
		end else begin
			strap_meta <= strap_resistor;
			strap_sync <= strap_meta;
			pin_meta <= {sync_clock, ov_comparator, enable_pin};
			pin_sync <= pin_meta;
			sync_clock_last <= pin_sync[2];
		end
	end

	// An open pin is pulled high externally, so it simply reads as one.
	logic pin_enable;
	assign pin_enable = pin_sync[0];
	logic ov_seen;
	assign ov_seen = pin_sync[1];

	// ----------------------------------------------------------------
	// Strap capture
	// ----------------------------------------------------------------
	logic [15:0] strap_mv;
	logic [15:0] strap_held;
	logic strap_taken;

	strap_lookup u_strap (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.code(strap_sync),
		.millivolts(strap_mv)
	);

	// Captured every cycle while initializing; later resistor changes are ignored.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			strap_held <= 16'h04b0;
			strap_taken <= 1'b0;
		end else if (!init_done) begin
			strap_held <= strap_mv;
			strap_taken <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	logic [7:0] operation;
	logic source_select;
	vout_mgr_pkg::setpoint_type setpoint;
	vout_mgr_pkg::loop_type loop_cfg;
	logic [15:0] vout_max;
	logic [15:0] ov_limit;
	logic ov_response;
	logic [7:0] over_under_fault_config;
	logic ov_limit_written;
	logic margins_written;
	logic wr;
	logic clear_faults;

	assign wr = psel && penable && pwrite;
	assign clear_faults = wr && (paddr == vout_mgr_pkg::offset_clear_faults);

	// Nominal derived figures follow the stored command until software takes over.
	logic [15:0] margin_step;
	logic [15:0] ov_default;
	assign margin_step = 16'((32'(setpoint.command) * vout_mgr_pkg::margin_percent) / 100);
	assign ov_default = 16'((32'(setpoint.command) * (100 + vout_mgr_pkg::ov_percent)) / 100);

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			operation <= 8'h00;
			source_select <= 1'b0;
			setpoint <= '0;
			vout_max <= vout_mgr_pkg::vout_max_reset;
			ov_limit <= 16'h0;
			ov_response <= vout_mgr_pkg::response_reset;
			over_under_fault_config <= 8'h00;
			loop_cfg <= {vout_mgr_pkg::loop_gain_reset, vout_mgr_pkg::loop_residual_reset};
			ov_limit_written <= 1'b0;
			margins_written <= 1'b0;
		end else begin
			if (!init_done) begin
				setpoint.command <= strap_mv;
			end else if (nvm_load) begin
				setpoint.command <= nvm_vout_command;
			end
			if (!margins_written) begin
				setpoint.margin_hi <= setpoint.command + margin_step;
				setpoint.margin_lo <= setpoint.command - margin_step;
			end
			if (!ov_limit_written) begin
				ov_limit <= ov_default;
			end
			if (wr) begin
				case (paddr)
					vout_mgr_pkg::offset_operation: begin
						operation <= pwdata[7:0];
						setpoint.margin_sel <= pwdata[5:4];
					end
					vout_mgr_pkg::offset_vout_command: setpoint.command <= pwdata[15:0];
					vout_mgr_pkg::offset_vout_trim: setpoint.trim <= pwdata[15:0];
					vout_mgr_pkg::offset_margin_high: begin
						setpoint.margin_hi <= pwdata[15:0];
						margins_written <= 1'b1;
					end
					vout_mgr_pkg::offset_margin_low: begin
						setpoint.margin_lo <= pwdata[15:0];
						margins_written <= 1'b1;
					end
					vout_mgr_pkg::offset_vout_max: vout_max <= pwdata[15:0];
					vout_mgr_pkg::offset_ov_limit: begin
						ov_limit <= pwdata[15:0];
						ov_limit_written <= 1'b1;
					end
					vout_mgr_pkg::offset_ov_response: ov_response <= pwdata[0];
					vout_mgr_pkg::offset_over_under_fault_config: begin
						over_under_fault_config <= pwdata[7:0];
						source_select <= pwdata[vout_mgr_pkg::source_select_bit];
					end
					vout_mgr_pkg::offset_loop_gain_residual_config:
						loop_cfg <= {pwdata[15:0], pwdata[31:16]};
					default: begin
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Target and ceiling
	// ----------------------------------------------------------------
	logic [15:0] strap_ceiling;
	logic [15:0] ceiling;
	logic [15:0] nominal;
	logic [15:0] next_target;

	assign strap_ceiling = 16'((32'(strap_held) * vout_mgr_pkg::ceiling_percent) / 100);
	assign ceiling = (vout_max < strap_ceiling) ? vout_max : strap_ceiling;

	always_comb begin
		case (setpoint.margin_sel)
			vout_mgr_pkg::margin_high: nominal = setpoint.margin_hi;
			vout_mgr_pkg::margin_low: nominal = setpoint.margin_lo;
			default: nominal = setpoint.command;
		endcase
		next_target = nominal + setpoint.trim;
		if (next_target > ceiling) begin
			next_target = ceiling;
		end
	end

	// The stored command is never touched here, so it reads back as written.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			target_mv <= 16'h0;
			ov_limit_mv <= 16'h0;
		end else begin
			target_mv <= next_target;
			ov_limit_mv <= ov_limit;
		end
	end

	// ----------------------------------------------------------------
	// Enable and fault control
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {off_type_idle, on_state, latched_state, hiccup_state} ctl_state_type;
	ctl_state_type state;
	logic requested;
	logic requested_last;
	logic timer_start;
	logic timer_running;
	logic timer_done;

	// Rising request counts as a re-enable that clears a latched fault.
	assign requested = init_done && (source_select ? operation[vout_mgr_pkg::operation_on_bit]
		: pin_enable);
	assign timer_start = (state == on_state) && ov_seen && (ov_response == vout_mgr_pkg::response_hiccup);

	hiccup_timer #(
		.interval(hiccup_interval)
	) u_hiccup (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.start(timer_start),
		.cancel(!requested),
		.running(timer_running),
		.done(timer_done)
	);

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state <= off_type_idle;
			requested_last <= 1'b0;
			output_enable <= 1'b0;
			fault_active <= 1'b0;
		end else begin
			requested_last <= requested;
			case (state)
				off_type_idle: begin
					if (requested) begin
						state <= on_state;
					end
				end
				on_state: begin
					if (!requested) begin
						state <= off_type_idle;
					end else if (ov_seen) begin
						state <= (ov_response == vout_mgr_pkg::response_hiccup) ? hiccup_state
							: latched_state;
					end
				end
				latched_state: begin
					if (clear_faults || (requested && !requested_last)) begin
						state <= off_type_idle;
					end
				end
				hiccup_state: begin
					if (!requested) begin
						state <= off_type_idle;
					end else if (timer_done) begin
						state <= on_state;
					end
				end
				default: state <= off_type_idle;
			endcase
			// Shutdown acts in the cycle the fault is seen, not one state later.
			output_enable <= (state == on_state || (state == off_type_idle && requested))
				&& requested && !ov_seen;
			fault_active <= (state == latched_state) || (state == hiccup_state);
		end
	end

	// ----------------------------------------------------------------
	// Switching-cycle loop update
	// ----------------------------------------------------------------
	// With an external clock the period is taken from its rising edges.
	logic [15:0] pwm_count;
	logic sync_rise;
	assign sync_rise = pin_sync[2] && !sync_clock_last;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pwm_count <= 16'h0;
			loop_update <= 1'b0;
		end else begin
			loop_update <= 1'b0;
			if (operation[0] ? sync_rise : (pwm_count == 16'(vout_mgr_pkg::pwm_cycles - 1))) begin
				pwm_count <= 16'h0;
				loop_update <= 1'b1;
			end else begin
				pwm_count <= pwm_count + 16'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// APB read path
	// ----------------------------------------------------------------
	logic [31:0] next_prdata;
	logic mapped;

	always_comb begin
		next_prdata = 32'h0;
		mapped = 1'b1;
		case (paddr)
			vout_mgr_pkg::offset_operation: next_prdata = {24'h0, operation};
			vout_mgr_pkg::offset_vout_command: next_prdata = {16'h0, setpoint.command};
			vout_mgr_pkg::offset_vout_trim: next_prdata = {16'h0, setpoint.trim};
			vout_mgr_pkg::offset_margin_high: next_prdata = {16'h0, setpoint.margin_hi};
			vout_mgr_pkg::offset_margin_low: next_prdata = {16'h0, setpoint.margin_lo};
			vout_mgr_pkg::offset_vout_max: next_prdata = {16'h0, vout_max};
			vout_mgr_pkg::offset_ov_limit: next_prdata = {16'h0, ov_limit};
			vout_mgr_pkg::offset_ov_response: next_prdata = {31'h0, ov_response};
			vout_mgr_pkg::offset_over_under_fault_config: next_prdata = {24'h0, over_under_fault_config};
			vout_mgr_pkg::offset_loop_gain_residual_config: next_prdata = {loop_cfg.residual, loop_cfg.gain};
			vout_mgr_pkg::offset_clear_faults: next_prdata = 32'h0;
			vout_mgr_pkg::offset_status:
				next_prdata = {26'h0, strap_taken, timer_running, fault_active, output_enable, state};
			vout_mgr_pkg::offset_target: next_prdata = {ceiling, target_mv};
			vout_mgr_pkg::offset_nvm_load: next_prdata = {16'h0, strap_held};
			default: mapped = 1'b0;
		endcase
	end

	// Zero-wait answer: pready rises in the first access cycle.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			if (psel && !penable && !pwrite) begin
				prdata <= next_prdata;
			end
		end
	end

endmodule // vout_setpoint_and_overvoltage_manager

`default_nettype wire

// [verification/board_model.sv]
/*
 * Board-side model: enable pin with its pull-up and the external sync clock.
 * Assumes the bench commands it; the sync clock idles low between bursts.
 */
`timescale 1ns/1ps
`default_nettype none

module board_model (
	input wire logic pin_drive,
	input wire logic pin_level,
	output logic enable_pin,
	output logic sync_clock
);
	// An undriven pin floats up to the pull-up level.
	assign enable_pin = pin_drive ? pin_level : 1'b1;
	initial sync_clock = 1'b0;
	// Edges sit off the system clock edges; the clock is steady before use.
	task automatic burst(input int n);
		#5;
		repeat (n) begin
			#160 sync_clock = 1'b1;
			#160 sync_clock = 1'b0;
		end
	endtask
endmodule // board_model

`default_nettype wire

// [verification/testbench.sv]
/*
 * Self-checking bench of the setpoint and over-voltage manager over APB.
 * Assumes the package offsets and a shortened hiccup interval.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
	localparam int hiccup = 20;
	localparam int ceil = 1800 * vout_mgr_pkg::ceiling_percent / 100;
	logic clk_sys, resetn, psel, penable, pwrite, pready, pslverr, e, init_done, nvm_load;
	logic ov_comparator, enable_pin, sync_clock, output_enable, loop_update, fault_active;
	logic pin_drive, pin_level;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [4:0] strap_resistor;
	logic [15:0] nvm_vout_command, target_mv, ov_limit_mv;
	logic [4:0] codes[4] = '{5'h00, 5'h01, 5'h1f, 5'h14};
	int mv[4] = '{1000, 600, 1200, 1800};
	int fails = 0;
	int n_checks = 0;
	int n_loop = 0;
	int snap;

	vout_setpoint_and_overvoltage_manager #(.hiccup_interval(hiccup))
		i_vout_setpoint_and_overvoltage_manager (.clk_sys, .resetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .strap_resistor, .init_done, .nvm_load,
		.nvm_vout_command, .enable_pin, .ov_comparator, .sync_clock, .output_enable,
		.target_mv, .ov_limit_mv, .loop_update, .fault_active);
	board_model i_board_model (.pin_drive, .pin_level, .enable_pin, .sync_clock);

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) if (loop_update === 1'b1) n_loop <= n_loop + 1;

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: saw %h, expected %h", $time, got, exp);
		end
	endtask
	// The request is held until ready is seen, then one idle cycle follows.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
		@(posedge clk_sys);
	endtask
	// One more edge lets registered outputs settle before a direct look.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
		@(posedge clk_sys);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(q, exp);
	endtask
	task automatic done(input string s);
		$display("Test %s finished", s);
	endtask
	task automatic restart(input logic [4:0] code);
		{resetn, init_done, strap_resistor} <= {2'b00, code};
		repeat (12) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (4) @(posedge clk_sys);
		init_done <= 1'b1;
		repeat (4) @(posedge clk_sys);
		strap_resistor <= 5'h02;
		repeat (4) @(posedge clk_sys);
	endtask
	task automatic ov_pulse;
		ov_comparator <= 1'b1;
		repeat (3) @(posedge clk_sys);
		ov_comparator <= 1'b0;
		repeat (8) @(posedge clk_sys);
		check(output_enable, 0);
	endtask
	task automatic end_of_test;
		$display("Checks %0d, mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		{psel, penable, pwrite, init_done, nvm_load, ov_comparator, pin_drive, pin_level} = '0;
		{resetn, paddr, pwdata, nvm_vout_command, strap_resistor} = '0;
		@(posedge clk_sys);
		for (int i = 0; i < 4; i++) begin
			restart(codes[i]);
			rd_chk(vout_mgr_pkg::offset_nvm_load, mv[i]);
		end
		done("strap");
		rd_chk(vout_mgr_pkg::offset_ov_response, 1);
		rd_chk(vout_mgr_pkg::offset_loop_gain_residual_config, 32'h00500080);
		wr(vout_mgr_pkg::offset_loop_gain_residual_config, 32'h00300090);
		rd_chk(vout_mgr_pkg::offset_loop_gain_residual_config, 32'h00300090);
		rd_chk(vout_mgr_pkg::offset_vout_max, 32'h0000ffff);
		nvm_vout_command <= 16'd1100;
		nvm_load <= 1'b1;
		@(posedge clk_sys);
		nvm_load <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rd_chk(vout_mgr_pkg::offset_vout_command, 1100);
		check(ov_limit_mv, 1265);
		done("defaults");
		wr(vout_mgr_pkg::offset_vout_command, 2500);
		rd_chk(vout_mgr_pkg::offset_vout_command, 2500);
		rd_chk(vout_mgr_pkg::offset_target, {ceil[15:0], ceil[15:0]});
		wr(vout_mgr_pkg::offset_vout_command, 1000);
		wr(vout_mgr_pkg::offset_vout_trim, 50);
		check(target_mv, 1050);
		check(ov_limit_mv, 1150);
		wr(vout_mgr_pkg::offset_operation, 32'h20);
		check(target_mv, 1100);
		wr(vout_mgr_pkg::offset_operation, 32'h10);
		check(target_mv, 1000);
		wr(vout_mgr_pkg::offset_vout_max, 1060);
		wr(vout_mgr_pkg::offset_operation, 32'h20);
		check(target_mv, 1060);
		wr(vout_mgr_pkg::offset_vout_max, 32'hffff);
		done("setpoint");
		check(output_enable, 1);
		wr(vout_mgr_pkg::offset_ov_response, 0);
		ov_pulse();
		repeat (40) @(posedge clk_sys);
		check({fault_active, output_enable}, 2'b10);
		wr(vout_mgr_pkg::offset_clear_faults, 1);
		repeat (10) @(posedge clk_sys);
		check(output_enable, 1);
		ov_pulse();
		{pin_drive, pin_level} <= 2'b10;
		repeat (10) @(posedge clk_sys);
		pin_drive <= 1'b0;
		repeat (10) @(posedge clk_sys);
		check({fault_active, output_enable}, 2'b01);
		wr(vout_mgr_pkg::offset_ov_response, 1);
		ov_pulse();
		repeat (2 * hiccup + 20) @(posedge clk_sys);
		check(output_enable, 1);
		wr(vout_mgr_pkg::offset_ov_limit, 1234);
		check(ov_limit_mv, 1234);
		done("fault");
		{pin_drive, pin_level} <= 2'b10;
		repeat (10) @(posedge clk_sys);
		check(output_enable, 0);
		wr(vout_mgr_pkg::offset_over_under_fault_config, 1);
		rd_chk(vout_mgr_pkg::offset_over_under_fault_config, 1);
		wr(vout_mgr_pkg::offset_operation, 32'ha0);
		repeat (10) @(posedge clk_sys);
		check({output_enable, target_mv}, {1'b1, 16'd1100});
		done("source");
		snap = n_loop;
		repeat (500) @(posedge clk_sys);
		check(n_loop - snap, 10);
		wr(vout_mgr_pkg::offset_operation, 32'ha1);
		repeat (5) @(posedge clk_sys);
		snap = n_loop;
		i_board_model.burst(10);
		repeat (10) @(posedge clk_sys);
		check(n_loop - snap, 10);
		done("loop");
		bus(1'b0, 8'h3c, 32'h0);
		check(e, 1);
		check(q, 32'h0);
		done("unmapped");
		end_of_test();
	end

	initial begin
		#400000;
		fails++;
		end_of_test();
	end
endmodule // testbench

`default_nettype wire

// [verification/vout_mgr_checker_sva.sv]
/*
 * Port-level checker of the setpoint and over-voltage manager.
 * Assumes one clock domain and the designer's registered APB answer.
 */
`timescale 1ns/1ps
`default_nettype none

module vout_mgr_checker (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic ov_comparator,
	input wire logic output_enable,
	input wire logic loop_update,
	input wire logic fault_active
);
	// ----------------------------------------------------------------
	// Sequences
	// ----------------------------------------------------------------
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_ov_hit;
		$rose(ov_comparator) && output_enable;
	endsequence

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	a_ready_after_setup: assert property (s_setup |=> pready)
		else $error("no ready after setup");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_prdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
		else $error("read data changed outside a read");
	a_ov_shutdown: assert property (s_ov_hit |-> ##[1:5] !output_enable)
		else $error("output not cut on over-voltage");
	a_ov_flag: assert property (s_ov_hit |-> ##[1:5] fault_active)
		else $error("fault not flagged");
	a_fault_holds_off: assert property ($rose(fault_active) |-> ##[0:3] !output_enable [*8])
		else $error("output back too soon after fault");
	a_loop_gap: assert property (loop_update |=> !loop_update [*2])
		else $error("loop updates too close");
	a_reset_quiet: assert property ($rose(resetn) |-> !output_enable && !fault_active)
		else $error("outputs active right after reset");
endmodule // vout_mgr_checker

bind vout_setpoint_and_overvoltage_manager vout_mgr_checker i_vout_mgr_checker (.clk_sys,
	.resetn, .psel, .penable, .pwrite, .prdata, .pready, .pslverr, .ov_comparator,
	.output_enable, .loop_update, .fault_active);

`default_nettype wire
